// ### common/timer_pkg.sv
`default_nettype none
package timer_pkg;
	// register byte addresses on the apb bus
	localparam logic [11:0] ctrl_addr = 12'h000;
	localparam logic [11:0] count_low_addr = 12'h004;
	localparam logic [11:0] count_high_addr = 12'h008;
	localparam logic [11:0] flags_addr = 12'h00c;
	localparam logic [11:0] enables_addr = 12'h010;
	localparam logic [11:0] compare_addr = 12'h014;
	localparam logic [11:0] pins_addr = 12'h018;
	// control field positions
	localparam int wide_access_pos = 7;
	localparam int routing_hi_pos = 6;
	localparam int prescale_hi_pos = 5;
	localparam int prescale_lo_pos = 4;
	localparam int routing_lo_pos = 3;
	localparam int sync_bypass_pos = 2;
	localparam int clock_source_pos = 1;
	localparam int run_pos = 0;
	// flag and enable positions
	localparam int overflow_pos = 1;
	// compare register layout
	localparam int compare_mode_lsb = 16;
	localparam logic [3:0] special_event_mode = 4'hb;
	// reset values
	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [15:0] count_reset = 16'h0000;
	localparam logic [15:0] compare_reset = 16'hffff;
	localparam logic [3:0] compare_mode_reset = 4'h0;
	// instruction clock is the system clock divided by this
	localparam int instr_div = 4;
endpackage : timer_pkg
`default_nettype wire

// ### rtl/edge_sync.sv
`default_nettype none
// two-stage synchroniser with rising edge detect after a seen falling edge
module edge_sync
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic enable_in,
	input wire logic bypass_in,
	input wire logic raw_in,
	output logic rise_out
);
	typedef struct packed
	{
		logic meta;
		logic sync;
		logic last;
		logic armed;
		logic rise;
	} state_type;
	state_type s_q;
	state_type s_d;
	logic sample;

	////////////////////////////////////////////////////////////////
	// bypass takes the raw level; only stage two reads stage one
	always_comb
	begin
		s_d = s_q;
		s_d.meta = raw_in;
		s_d.sync = s_q.meta;
		sample = bypass_in ? raw_in : s_q.sync;
		s_d.last = sample;
		s_d.rise = 1'b0;
		if (s_q.last && !sample)
			s_d.armed = 1'b1;
		if (!s_q.last && sample && s_q.armed)
			s_d.rise = 1'b1;
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			s_q <= '0;
		else if (enable_in)
			s_q <= s_d;
	end

	assign rise_out = s_q.rise;
endmodule : edge_sync
`default_nettype wire

// ### rtl/prescaler.sv
`default_nettype none
// divides tick pulses by 1, 2, 4 or 8
module prescaler
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic enable_in,
	input wire logic clear_in,
	input wire logic tick_in,
	input wire logic [1:0] select_in,
	output logic tick_out
);
	typedef struct packed
	{
		logic [2:0] count;
	} state_type;
	state_type s_q;
	state_type s_d;
	logic [2:0] mask;

	////////////////////////////////////////////////////////////////
	// output fires when masked count bits are all ones
	always_comb
	begin
		s_d = s_q;
		unique case (select_in)
			2'h0: mask = 3'h0;
			2'h1: mask = 3'h1;
			2'h2: mask = 3'h3;
			2'h3: mask = 3'h7;
		endcase
		tick_out = tick_in && ((s_q.count & mask) == mask) && !clear_in;
		if (clear_in)
			s_d.count = 3'h0;
		else if (tick_in)
			s_d.count = s_q.count + 3'h1;
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			s_q <= '0;
		else if (enable_in)
			s_q <= s_d;
	end
endmodule : prescaler
`default_nettype wire

// ### rtl/timer_counter.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`default_nettype none
module timer_counter
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_clock_pin_in,
	input wire logic aux_osc_in,
	input wire logic aux_oscillator_enable_in,
	input wire logic [1:0] port_direction_bits_in,
	input wire logic [1:0] port_pins_in,
	output logic [1:0] pin_oe_out,
	output logic [1:0] port_read_out,
	output logic overflow_irq_out,
	output logic [1:0] unit_uses_this_timer_out,
	output logic [15:0] count_out
);
	typedef struct packed
	{
		logic [7:0] ctrl;
		logic [15:0] count;
		logic [7:0] high_buf;
		logic overflow_flag;
		logic overflow_irq_enable;
		logic [15:0] compare_value;
		logic [3:0] compare_mode;
		logic [1:0] div4;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic irq;
		logic [1:0] route;
		logic [1:0] oe;
		logic [1:0] pread;
	} state_type;
	state_type s_q;
	state_type s_d;

	logic ext_raw;
	logic ext_rise;
	logic instr_tick;
	logic source_tick;
	logic count_tick;
	logic pre_clear;
	logic acc;
	logic wr;
	logic rd;
	logic low_write;
	logic match;
	logic wide;

	////////////////////////////////////////////////////////////////
	// clock source selection
	// oscillator replaces the pin when enabled
	assign ext_raw = aux_oscillator_enable_in ? aux_osc_in : external_clock_pin_in;
	// bypass only honoured with external source
	// source and bypass bits pick the operating mode
	edge_sync ext_sync
	(
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.enable_in(clk_en_in),
		.bypass_in(s_q.ctrl[timer_pkg::sync_bypass_pos]),
		.raw_in(ext_raw),
		.rise_out(ext_rise)
	);
	// instruction tick every fourth clock, else pin edges
	assign instr_tick = (s_q.div4 == 2'(timer_pkg::instr_div - 1));
	assign source_tick = s_q.ctrl[timer_pkg::clock_source_pos] ? ext_rise : instr_tick;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign low_write = wr && (paddr == timer_pkg::count_low_addr);
	assign wide = s_q.ctrl[timer_pkg::wide_access_pos];
	// prescaler cleared by low byte writes only
	assign pre_clear = low_write;
	// prescale division of the selected tick
	prescaler pre
	(
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.enable_in(clk_en_in),
		.clear_in(pre_clear),
		.tick_in(source_tick && s_q.ctrl[timer_pkg::run_pos]),
		.select_in(s_q.ctrl[timer_pkg::prescale_hi_pos:timer_pkg::prescale_lo_pos]),
		.tick_out(count_tick)
	);
	// match only counts in special event mode
	// compare value thereby sets the period
	assign match = (s_q.compare_mode == timer_pkg::special_event_mode)
		&& (s_q.count == s_q.compare_value);

	////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		s_d = s_q;
		s_d.div4 = s_q.div4 + 2'h1;
		s_d.ready = 1'b0;
		s_d.err = 1'b0;
		// counting only while run bit set
		if (count_tick)
		begin
			s_d.count = s_q.count + 16'h0001;
			if (s_q.count == 16'hffff)
				s_d.overflow_flag = 1'b1;
		end
		// no flag set on trigger clear
		if (match)
			s_d.count = 16'h0000;
		// apb setup cycle answers in access phase with zero wait
		if (psel && !penable)
		begin
			s_d.ready = 1'b1;
			s_d.rdata = 32'h0;
			unique case (paddr)
				timer_pkg::ctrl_addr: s_d.rdata = {24'h0, s_q.ctrl};
				timer_pkg::count_low_addr:
				begin
					s_d.rdata = {24'h0, s_q.count[7:0]};
					if (wide && !pwrite)
						s_d.high_buf = s_q.count[15:8];
				end
				// high address reads buffer in wide mode
				timer_pkg::count_high_addr:
					s_d.rdata = {24'h0, wide ? s_q.high_buf : s_q.count[15:8]};
				timer_pkg::flags_addr:
					s_d.rdata = {30'h0, s_q.overflow_flag, 1'b0};
				timer_pkg::enables_addr:
					s_d.rdata = {30'h0, s_q.overflow_irq_enable, 1'b0};
				timer_pkg::compare_addr:
					s_d.rdata = {12'h0, s_q.compare_mode, s_q.compare_value};
				timer_pkg::pins_addr: s_d.rdata = {30'h0, s_q.pread};
				default: s_d.err = 1'b1;
			endcase
		end
		// writes land in the access cycle; they follow the counter update
		if (wr)
		begin
			unique case (paddr)
				timer_pkg::ctrl_addr: s_d.ctrl = pwdata[7:0];
				// low write commits buffered high byte in wide mode
				timer_pkg::count_low_addr:
					s_d.count = {wide ? s_q.high_buf : s_d.count[15:8], pwdata[7:0]};
				// high byte goes to buffer in wide mode
				timer_pkg::count_high_addr:
					if (wide)
						s_d.high_buf = pwdata[7:0];
					else
						s_d.count = {pwdata[7:0], s_d.count[7:0]};
				// flag cleared by write of zero; a wrap in the same cycle wins
				timer_pkg::flags_addr:
					s_d.overflow_flag = (s_q.overflow_flag && pwdata[timer_pkg::overflow_pos])
						|| (count_tick && s_q.count == 16'hffff);
				timer_pkg::enables_addr:
					s_d.overflow_irq_enable = pwdata[timer_pkg::overflow_pos];
				timer_pkg::compare_addr:
				begin
					s_d.compare_value = pwdata[15:0];
					s_d.compare_mode = pwdata[timer_pkg::compare_mode_lsb +: 4];
				end
				// the refusal already stood with pready; let it drop with it
				default: s_d.err = 1'b0;
			endcase
		end
		if (rd || wr)
			s_d.ready = 1'b0;
		// request only while enable is set
		s_d.irq = s_d.overflow_flag && s_d.overflow_irq_enable;
		// routing 1x both, 01 second only, 00 none
		s_d.route[1] = s_d.ctrl[timer_pkg::routing_hi_pos] || s_d.ctrl[timer_pkg::routing_lo_pos];
		s_d.route[0] = s_d.ctrl[timer_pkg::routing_hi_pos];
		// oscillator pins inputs and read zero
		s_d.oe = aux_oscillator_enable_in ? 2'h0 : ~port_direction_bits_in;
		s_d.pread = aux_oscillator_enable_in ? 2'h0 : port_pins_in;
	end

	////////////////////////////////////////////////////////////////
	// state register; clock enable freezes everything
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			s_q <= '0;
			s_q.ctrl <= timer_pkg::ctrl_reset;
			s_q.count <= timer_pkg::count_reset;
			s_q.compare_value <= timer_pkg::compare_reset;
			s_q.compare_mode <= timer_pkg::compare_mode_reset;
		end
		else if (clk_en_in)
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign overflow_irq_out = s_q.irq;
	assign unit_uses_this_timer_out = s_q.route;
	assign count_out = s_q.count;
	assign pin_oe_out = s_q.oe;
	assign port_read_out = s_q.pread;
endmodule : timer_counter
`default_nettype wire

// ### test/ext_clock_source.sv
`default_nettype none
// far-side clock source: idles low and moves only while pulses are asked for
module ext_clock_source
(
	output logic pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin_out = 1'b0;
	// a long half period gives a slow source, a short one a prompt source
	// a small lead keeps every pin change off the sampling clock edge
	task automatic pulses(input int n, input int half_ns);
		#2;
		repeat (n)
		begin
			#half_ns pin_out = 1'b1;
			#half_ns pin_out = 1'b0;
		end
	endtask : pulses
endmodule : ext_clock_source
`default_nettype wire

// ### test/tb_timer_counter.sv
`default_nettype none
module tb_timer_counter;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] ctl = timer_pkg::ctrl_addr;
	localparam logic [11:0] lo = timer_pkg::count_low_addr;
	localparam logic [11:0] hi = timer_pkg::count_high_addr;
	localparam logic [11:0] flg = timer_pkg::flags_addr;
	logic core_clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr, err, ext_pin, aux, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] dir, pins, oe, prd, uses;
	logic [15:0] count, mx, c;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	ext_clock_source i_ext_clock_source (.pin_out(ext_pin));
	timer_counter i_timer_counter (.core_clk_in, .reset_n_in, .clk_en_in(1'b1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_clock_pin_in(ext_pin),
		.aux_osc_in(1'b0), .aux_oscillator_enable_in(aux), .port_direction_bits_in(dir),
		.port_pins_in(pins), .pin_oe_out(oe), .port_read_out(prd), .overflow_irq_out(irq),
		.unit_uses_this_timer_out(uses), .count_out(count));
	initial
	begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	// a hung wait ends the run as a failure
	always @(posedge core_clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one transfer held until pready, then an idle edge so psel is never set twice at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_in);
		penable <= 1'b1;
		// pready stands for the one access cycle only: take the answer while it stands
		wait (pready === 1'b1);
		rd = prdata;
		err = pslverr;
		@(posedge core_clk_in);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk_in);
	endtask : apb
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset_n_in = 1'b0;
		{psel, penable, pwrite, aux} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		dir = 2'b01;
		pins = 2'b10;
		repeat (6) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		@(posedge core_clk_in);
		apb(1'b0, ctl, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		apb(1'b1, 12'h040, 32'h5a);
		chk("refused", err, 1'b1);
		// wide mode: high byte parks in the buffer until the low byte lands
		apb(1'b1, ctl, 32'h80);
		apb(1'b1, hi, 32'h12);
		chk("hi buffered", count, 16'h0000);
		apb(1'b1, lo, 32'h34);
		chk("commit", count, 16'h1234);
		apb(1'b0, lo, 32'h0);
		apb(1'b0, hi, 32'h0);
		chk("hi snapshot", rd, 32'h12);
		apb(1'b1, ctl, 32'h0);
		apb(1'b1, hi, 32'h0);
		chk("byte mode hi", count, 16'h0034);
		// internal tick every four clocks, then divided by 1, 2, 4, 8
		for (int ps = 0; ps < 4; ps++)
		begin
			apb(1'b1, lo, 32'h0);
			apb(1'b1, ctl, 32'h1 | (ps << 4));
			repeat (16 << ps) @(posedge core_clk_in);
			apb(1'b1, ctl, 32'h0);
			chk("prescale", count >= 3 && count <= 5, 1'b1);
		end
		// wrap from ffff latches the flag; irq only while enabled
		apb(1'b1, timer_pkg::enables_addr, 32'h2);
		apb(1'b1, hi, 32'hff);
		apb(1'b1, lo, 32'hff);
		apb(1'b1, ctl, 32'h1);
		for (int i = 0; i < 40 && irq !== 1'b1; i++)
			@(posedge core_clk_in);
		apb(1'b1, ctl, 32'h0);
		chk("wrapped", count < 16'h0010, 1'b1);
		apb(1'b1, timer_pkg::enables_addr, 32'h0);
		chk("irq gated", irq, 1'b0);
		apb(1'b0, flg, 32'h0);
		chk("flag sticky", rd[1], 1'b1);
		c = count;
		apb(1'b1, flg, 32'h0);
		chk("clear keeps count", count, c);
		apb(1'b0, flg, 32'h0);
		chk("flag cleared", rd[1], 1'b0);
		// special event: the compare value becomes the period, flag untouched
		apb(1'b1, lo, 32'h0);
		apb(1'b1, timer_pkg::compare_addr, 32'h000b0009);
		apb(1'b1, ctl, 32'h1);
		mx = 16'h0000;
		repeat (150)
		begin
			@(posedge core_clk_in);
			if (count > mx)
				mx = count;
		end
		apb(1'b1, ctl, 32'h0);
		chk("period", mx, 16'h0009);
		apb(1'b0, flg, 32'h0);
		chk("no flag", rd[1], 1'b0);
		apb(1'b1, timer_pkg::compare_addr, 32'h0000ffff);
		// routing field: 1x both units, 01 second unit only, 00 none
		for (int r = 0; r < 4; r++)
		begin
			apb(1'b1, ctl, {r[1], 2'b00, r[0], 3'b000});
			chk("routing", uses, {r[1] | r[0], r[1]});
		end
		// oscillator enable turns both pins into inputs that read zero
		aux <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		chk("osc pins", {oe, prd}, 4'h0);
		aux <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		chk("port pins", {oe, prd}, {~dir, pins});
		// external edges: the first rise is skipped until a fall has been seen
		apb(1'b1, lo, 32'h0);
		for (int s = 0; s < 2; s++)
		begin
			apb(1'b1, ctl, 32'h3 | (s << 2));
			i_ext_clock_source.pulses(3, 50 - 30 * s);
			repeat (6) @(posedge core_clk_in);
			chk("ext count", count, 16'(2 + 3 * s));
		end
		tally_and_finish();
	end
endmodule : tb_timer_counter
bind timer_counter timer_counter_props i_timer_counter_props (.core_clk_in, .reset_n_in, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .aux_oscillator_enable_in, .pin_oe_out,
	.port_read_out, .overflow_irq_out, .unit_uses_this_timer_out, .count_out);
`default_nettype wire

// ### test/timer_counter_props.sv
`default_nettype none
module timer_counter_props
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic aux_oscillator_enable_in,
	input wire logic [1:0] pin_oe_out,
	input wire logic [1:0] port_read_out,
	input wire logic overflow_irq_out,
	input wire logic [1:0] unit_uses_this_timer_out,
	input wire logic [15:0] count_out
);
	logic [7:0] ctrl_q;
	logic en_q;
	logic wr;
	assign wr = psel && penable && pwrite;
	// shadow of control and enable writes, since only the bus is visible here
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ctrl_q <= 8'h00;
			en_q <= 1'b0;
		end
		else if (wr && paddr == timer_pkg::ctrl_addr)
			ctrl_q <= pwdata[7:0];
		else if (wr && paddr == timer_pkg::enables_addr)
			en_q <= pwdata[1];
	end
	default clocking dc @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_step;
		count_out == $past(count_out) + 16'h0001;
	endsequence
	// a trigger clear or a bus access may cut the quiet gap short
	sequence s_quiet;
		(count_out == $past(count_out) || count_out == 16'h0000 || psel) [*3];
	endsequence
	property p_ans;
		psel && penable |-> pready;
	endproperty
	a_ans: assert property (p_ans) else $error("no zero-wait answer");
	property p_err;
		psel && penable && paddr > timer_pkg::pins_addr |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_step;
		$changed(count_out) && !$past(wr) |-> s_step or count_out == 16'h0000;
	endproperty
	a_step: assert property (p_step) else $error("count jumped");
	property p_hold;
		!ctrl_q[0] && !$past(ctrl_q[0]) && !$past(wr) |-> $stable(count_out) || count_out == 16'h0000;
	endproperty
	a_hold: assert property (p_hold) else $error("stopped count moved");
	property p_route;
		$stable(ctrl_q) |-> unit_uses_this_timer_out == {ctrl_q[6] | ctrl_q[3], ctrl_q[6]};
	endproperty
	a_route: assert property (p_route) else $error("wrong time base routing");
	property p_osc;
		aux_oscillator_enable_in && $past(aux_oscillator_enable_in) |-> pin_oe_out == 2'b00 && port_read_out == 2'b00;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator pins not inputs");
	property p_irq;
		!en_q && !$past(en_q) |-> !overflow_irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("irq while disabled");
	property p_tick;
		ctrl_q[5:0] == 6'h01 && !$past(wr) ##0 s_step |=> s_quiet;
	endproperty
	a_tick: assert property (p_tick) else $error("internal tick too fast");
endmodule : timer_counter_props
`default_nettype wire
